// >>> ptl_cfg.svh
// Purpose: Constants for the drive timing and supervision block
// Assumes: Register byte address is four times the register index
// Notes:   All programmable times count millisecond ticks
//
// What this block does
// - Start-up torque for programmed ms window
// - End-of-run holding torque for programmed ms
// - Idle pause on direction reversal, except one made during start-up
// - Manual run after key held, 5 ms steps
// - Manual hold time writable only at standstill
// - Brake stays released programmed ms after run
// - Motor voltage averaged over programmed window
// - Ten 32-bit storage registers, no effect
// - Status bit 13 when voltage under limit
// - Runs start only above voltage limit
// - Below 19.2 V: power-good fail, block runs
// - Programmable upper temperature limit in Celsius
// - Abort speed threshold as percent of target
`ifndef PTL_CFG_SVH
`define PTL_CFG_SVH
`define PTL_CLK_MHZ      32'h000000C8
`define PTL_TICK_US      32'h000003E8
`define PTL_IX_PCT       8'h3C
`define PTL_IX_ABORT_TO  8'h4A
`define PTL_IX_START_WIN 8'h4C
`define PTL_IX_END_WIN   8'h4E
`define PTL_IX_REV       8'h50
`define PTL_IX_HOLD      8'h52
`define PTL_IX_BRAKE     8'h54
`define PTL_IX_FILT      8'h56
`define PTL_IX_GP0       8'h58
`define PTL_IX_VLIM      8'h6C
`define PTL_IX_TLIM      8'h6E
`define PTL_IX_CTRL      8'h70
`define PTL_IX_STAT      8'h72
`define PTL_IX_IRQ_STAT  8'h74
`define PTL_IX_IRQ_CLR   8'h76
`define PTL_IX_IRQ_EN    8'h78
`define PTL_GP_NUM       4'hA
`define PTL_RST_PCT      16'h001E
`define PTL_RST_ABORT_TO 16'h00C8
`define PTL_RST_WIN      16'h00C8
`define PTL_RST_REV      16'h000A
`define PTL_RST_HOLD     16'h03E8
`define PTL_RST_BRAKE    16'h03E8
`define PTL_RST_FILT     16'h0064
`define PTL_RST_VLIM     16'h00B9
`define PTL_RST_TLIM     16'h0046
`define PTL_PG_LIMIT     16'h00C0
`define PTL_HOLD_STEP    20'h00005
`define PTL_PCT_FULL     32'h00000064
`define PTL_CT_RUN       0
`define PTL_CT_DIR       1
`define PTL_CT_JOG       2
`define PTL_CT_W         3
`define PTL_ST_RUN       0
`define PTL_ST_PGF       1
`define PTL_ST_OT        2
`define PTL_ST_BRK       3
`define PTL_ST_UV        13
`define PTL_EV_DONE      0
`define PTL_EV_ABORT     1
`define PTL_EV_UV        2
`define PTL_EV_OT        3
`define PTL_EV_REF       4
`define PTL_EV_W         5
`endif

// >>> ptl_pkg.sv
// Purpose: Types for the drive timing and supervision block
// Assumes: Constants live in ptl_cfg.svh
// Notes:   None
package ptl_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_REV, ST_START, ST_RUN, ST_HOLD} ptl_state_type;
   typedef enum logic [1:0] {TQ_STANDSTILL, TQ_STARTUP, TQ_MAX, TQ_END_HOLD} ptl_torque_type;
endpackage : ptl_pkg

// >>> ptl_drive_timer.sv
// Purpose: Run timing, brake hold-off and supply/temperature supervision
// Assumes: Measured values come from logic on clk_i
// Notes:   APB slave, no wait state on any transfer
`timescale 1ns/1ps
`include "ptl_cfg.svh"
module ptl_drive_timer
#(
   parameter int unsigned TICK_CYC = `PTL_TICK_US * `PTL_CLK_MHZ
)
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [11:0]       paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic [15:0]       umot_i,
   input  wire logic [15:0]       temp_i,
   input  wire logic [15:0]       speed_i,
   input  wire logic [15:0]       target_speed_i,
   input  wire logic              manual_key_i,
   output ptl_pkg::ptl_torque_type torque_o,
   output logic                   drive_en_o,
   output logic                   dir_o,
   output logic                   brake_rel_o,
   output logic                   irq_o
);
   import ptl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic                  rst_q1_ff;
   logic                  rst_n_ff;
   logic [31:0]           tick_cnt_ff;
   logic                  tick_ff;
   logic [15:0]           abort_to_ff;
   logic [15:0]           start_win_ff;
   logic [15:0]           end_win_ff;
   logic [15:0]           rev_ff;
   logic [15:0]           hold_ff;
   logic [15:0]           brake_hold_ff;
   logic [15:0]           filt_ff;
   logic [15:0]           vlim_ff;
   logic [15:0]           tlim_ff;
   logic [15:0]           pct_ff;
   logic [31:0]           gp_ff [`PTL_GP_NUM];
   logic [`PTL_CT_W-1:0]  ctrl_ff;
   logic [`PTL_EV_W-1:0]  irq_stat_ff;
   logic [`PTL_EV_W-1:0]  irq_en_ff;
   logic [`PTL_EV_W-1:0]  ev;
   logic [`PTL_EV_W-1:0]  clr;
   logic                  pready_ff;
   logic                  pslverr_ff;
   logic [31:0]           prdata_ff;
   logic [7:0]            idx;
   logic                  aligned;
   logic [7:0]            gp_off;
   logic [3:0]            gp_k;
   logic                  gp_hit;
   logic                  setup;
   logic                  wr_ok;
   logic [31:0]           rd_data;
   logic [31:0]           st_word;
   logic                  rd_hit;
   logic [15:0]           win_cnt_ff;
   logic [31:0]           sum_ff;
   logic [15:0]           win_n;
   logic [31:0]           sum_nxt;
   logic [31:0]           lim_n;
   logic [31:0]           pg_n;
   logic                  uv_ff;
   logic                  vok_ff;
   logic                  pgf_ff;
   logic                  ot_ff;
   logic                  uv_d_ff;
   logic                  ot_d_ff;
   logic                  key_q1_ff;
   logic                  key_q2_ff;
   logic                  man_act;
   logic [19:0]           key_ms_ff;
   logic [19:0]           hold_lim;
   logic                  man_ok;
   logic                  req;
   logic                  want_dir;
   logic                  can_go;
   logic                  slow;
   logic [15:0]           slow_ms_ff;
   ptl_state_type         state_ff;
   ptl_state_type         nxt_state;
   logic [15:0]           ph_cnt_ff;
   logic                  ev_done;
   logic                  ev_abort;
   logic                  ev_ref;
   logic                  brk_busy_ff;
   logic [15:0]           brk_cnt_ff;
   ptl_torque_type        torque_ff;
   logic                  drive_en_ff;
   logic                  dir_ff;
   logic                  brake_rel_ff;
   logic                  irq_ff;

   ////////////////////////////////////////////////////////////////////////
   // Reset release is synchronised, assertion stays asynchronous
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_q1_ff <= 1'b0;
         rst_n_ff  <= 1'b0;
      end
      else
      begin
         rst_q1_ff <= 1'b1;
         rst_n_ff  <= rst_q1_ff;
      end
   end

   // Millisecond tick; a phase starts mid-tick, so a window is N-1..N ms
   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         tick_cnt_ff <= 32'h0;
         tick_ff     <= 1'b0;
      end
      else if (tick_cnt_ff == TICK_CYC - 32'h1)
      begin
         tick_cnt_ff <= 32'h0;
         tick_ff     <= 1'b1;
      end
      else
      begin
         tick_cnt_ff <= tick_cnt_ff + 32'h1;
         tick_ff     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign idx     = paddr_i[9:2];
   assign aligned = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0);
   assign gp_off  = idx - `PTL_IX_GP0;
   assign gp_k    = gp_off[4:1];
   assign gp_hit  = (idx >= `PTL_IX_GP0) && (gp_off[7:5] == 3'h0) && !gp_off[0] && (gp_k < `PTL_GP_NUM);
   assign setup   = psel_i && !penable_i;
   assign wr_ok   = psel_i && penable_i && pready_ff && pwrite_i && !pslverr_ff;
   assign clr     = (wr_ok && (idx == `PTL_IX_IRQ_CLR)) ? pwdata_i[`PTL_EV_W-1:0] : '0;

   always_comb
   begin
      st_word                = 32'h0;
      st_word[`PTL_ST_RUN]   = (state_ff != ST_IDLE);
      st_word[`PTL_ST_PGF]   = pgf_ff;
      st_word[`PTL_ST_OT]    = ot_ff;
      st_word[`PTL_ST_BRK]   = brake_rel_ff;
      st_word[`PTL_ST_UV]    = uv_ff;
   end

   always_comb
   begin
      rd_data = 32'h0;
      rd_hit  = 1'b1;
      if (gp_hit)
         rd_data = gp_ff[gp_k];
      else
      begin
         case (idx)
            `PTL_IX_PCT       : rd_data = {16'h0, pct_ff};
            `PTL_IX_ABORT_TO  : rd_data = {16'h0, abort_to_ff};
            `PTL_IX_START_WIN : rd_data = {16'h0, start_win_ff};
            `PTL_IX_END_WIN   : rd_data = {16'h0, end_win_ff};
            `PTL_IX_REV       : rd_data = {16'h0, rev_ff};
            `PTL_IX_HOLD      : rd_data = {16'h0, hold_ff};
            `PTL_IX_BRAKE     : rd_data = {16'h0, brake_hold_ff};
            `PTL_IX_FILT      : rd_data = {16'h0, filt_ff};
            `PTL_IX_VLIM      : rd_data = {16'h0, vlim_ff};
            `PTL_IX_TLIM      : rd_data = {16'h0, tlim_ff};
            `PTL_IX_CTRL      : rd_data = {29'h0, ctrl_ff};
            `PTL_IX_STAT      : rd_data = st_word;
            `PTL_IX_IRQ_STAT  : rd_data = {27'h0, irq_stat_ff};
            `PTL_IX_IRQ_EN    : rd_data = {27'h0, irq_en_ff};
            `PTL_IX_IRQ_CLR   : rd_data = 32'h0;
            default           : rd_hit  = 1'b0;
         endcase
      end
      rd_hit = rd_hit && aligned;
   end

   // Answer is decided in setup so the access phase sees stable data
   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0;
      end
      else
      begin
         pready_ff <= setup;
         if (setup)
         begin
            pslverr_ff <= !rd_hit;
            prdata_ff  <= pwrite_i ? 32'h0 : rd_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         pct_ff        <= `PTL_RST_PCT;
         abort_to_ff   <= `PTL_RST_ABORT_TO;
         start_win_ff  <= `PTL_RST_WIN;
         end_win_ff    <= `PTL_RST_WIN;
         rev_ff        <= `PTL_RST_REV;
         hold_ff       <= `PTL_RST_HOLD;
         brake_hold_ff <= `PTL_RST_BRAKE;
         filt_ff       <= `PTL_RST_FILT;
         vlim_ff       <= `PTL_RST_VLIM;
         tlim_ff       <= `PTL_RST_TLIM;
         ctrl_ff       <= '0;
         irq_en_ff     <= '0;
      end
      else if (wr_ok && !gp_hit)
      begin
         case (idx)
            `PTL_IX_PCT       : pct_ff        <= pwdata_i[15:0];
            `PTL_IX_ABORT_TO  : abort_to_ff   <= pwdata_i[15:0];
            `PTL_IX_START_WIN : start_win_ff  <= pwdata_i[15:0];
            `PTL_IX_END_WIN   : end_win_ff    <= pwdata_i[15:0];
            `PTL_IX_REV       : rev_ff        <= pwdata_i[15:0];
            `PTL_IX_HOLD      : if (state_ff == ST_IDLE) hold_ff <= pwdata_i[15:0];
            `PTL_IX_BRAKE     : brake_hold_ff <= pwdata_i[15:0];
            `PTL_IX_FILT      : filt_ff       <= pwdata_i[15:0];
            `PTL_IX_VLIM      : vlim_ff       <= pwdata_i[15:0];
            `PTL_IX_TLIM      : tlim_ff       <= pwdata_i[15:0];
            `PTL_IX_CTRL      : ctrl_ff       <= pwdata_i[`PTL_CT_W-1:0];
            `PTL_IX_IRQ_EN    : irq_en_ff     <= pwdata_i[`PTL_EV_W-1:0];
            default           : ;
         endcase
      end
   end

   // Plain storage; keeping it across power cycles is up to the owner
   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         for (int i = 0; i < `PTL_GP_NUM; i++)
            gp_ff[i] <= 32'h0;
      end
      else if (wr_ok && gp_hit)
         gp_ff[gp_k] <= pwdata_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // Mean compared as sum against limit times samples, avoids a divider
   assign win_n   = win_cnt_ff + 16'h1;
   assign sum_nxt = sum_ff + {16'h0, umot_i};
   assign lim_n   = vlim_ff * win_n;
   assign pg_n    = `PTL_PG_LIMIT * win_n;

   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         win_cnt_ff <= 16'h0;
         sum_ff     <= 32'h0;
         uv_ff      <= 1'b0;
         vok_ff     <= 1'b0;
         pgf_ff     <= 1'b0;
      end
      else if (tick_ff)
      begin
         if (win_n >= filt_ff)
         begin
            win_cnt_ff <= 16'h0;
            sum_ff     <= 32'h0;
            uv_ff      <= sum_nxt < lim_n;
            vok_ff     <= sum_nxt > lim_n;
            pgf_ff     <= sum_nxt < pg_n;
         end
         else
         begin
            win_cnt_ff <= win_n;
            sum_ff     <= sum_nxt;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         ot_ff   <= 1'b0;
         ot_d_ff <= 1'b0;
         uv_d_ff <= 1'b0;
      end
      else
      begin
         ot_ff   <= temp_i > tlim_ff;
         ot_d_ff <= ot_ff;
         uv_d_ff <= uv_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         key_q1_ff <= 1'b0;
         key_q2_ff <= 1'b0;
      end
      else
      begin
         key_q1_ff <= manual_key_i;
         key_q2_ff <= key_q1_ff;
      end
   end

   assign man_act  = key_q2_ff || ctrl_ff[`PTL_CT_JOG];
   assign hold_lim = {4'h0, hold_ff} * `PTL_HOLD_STEP;
   assign man_ok   = man_act && (key_ms_ff >= hold_lim);

   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         key_ms_ff <= 20'h0;
      else if (!man_act)
         key_ms_ff <= 20'h0;
      else if (tick_ff && !man_ok)
         key_ms_ff <= key_ms_ff + 20'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   assign req      = ctrl_ff[`PTL_CT_RUN] || man_ok;
   assign want_dir = ctrl_ff[`PTL_CT_DIR];
   assign can_go   = vok_ff && !pgf_ff && !ot_ff;
   assign slow     = ({16'h0, speed_i} * `PTL_PCT_FULL) < ({16'h0, pct_ff} * {16'h0, target_speed_i});

   always_comb
   begin
      nxt_state = state_ff;
      ev_done   = 1'b0;
      ev_abort  = 1'b0;
      ev_ref    = 1'b0;
      unique case (state_ff)
         ST_IDLE:
            if (req && !can_go)
               ev_ref = 1'b1;
            else if (req && (want_dir != dir_ff))
               nxt_state = ST_REV;
            else if (req)
               nxt_state = ST_START;
         ST_REV:
            if (!req)
               nxt_state = ST_IDLE;
            else if (ph_cnt_ff >= rev_ff)
               nxt_state = ST_START;
         ST_START:
            if (pgf_ff)
            begin
               nxt_state = ST_HOLD;
               ev_abort  = 1'b1;
            end
            else if (!req)
            begin
               nxt_state = ST_HOLD;
               ev_done   = 1'b1;
            end
            else if (ph_cnt_ff >= start_win_ff)
               nxt_state = ST_RUN;
         ST_RUN:
            if (pgf_ff || (slow_ms_ff > abort_to_ff))
            begin
               nxt_state = ST_HOLD;
               ev_abort  = 1'b1;
            end
            else if (!req)
            begin
               nxt_state = ST_HOLD;
               ev_done   = 1'b1;
            end
            else if (want_dir != dir_ff)
               nxt_state = ST_REV;
         ST_HOLD:
            if (ph_cnt_ff >= end_win_ff)
               nxt_state = ST_IDLE;
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         state_ff  <= ST_IDLE;
         ph_cnt_ff <= 16'h0;
         dir_ff    <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (nxt_state != state_ff)
            ph_cnt_ff <= 16'h0;
         else if (tick_ff && (ph_cnt_ff != 16'hFFFF))
            ph_cnt_ff <= ph_cnt_ff + 16'h1;
         if (nxt_state == ST_START)
            dir_ff <= want_dir;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         slow_ms_ff <= 16'h0;
      else if ((state_ff != ST_RUN) || !slow)
         slow_ms_ff <= 16'h0;
      else if (tick_ff && (slow_ms_ff != 16'hFFFF))
         slow_ms_ff <= slow_ms_ff + 16'h1;
   end

   // Brake timer starts when motion ends, independent of the hold phase
   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         brk_busy_ff <= 1'b0;
         brk_cnt_ff  <= 16'h0;
      end
      else if ((nxt_state == ST_HOLD) && (state_ff != ST_HOLD))
      begin
         brk_busy_ff <= 1'b1;
         brk_cnt_ff  <= 16'h0;
      end
      else if (brk_busy_ff && (brk_cnt_ff >= brake_hold_ff))
         brk_busy_ff <= 1'b0;
      else if (brk_busy_ff && tick_ff)
         brk_cnt_ff <= brk_cnt_ff + 16'h1;
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      ev                = '0;
      ev[`PTL_EV_DONE]  = ev_done;
      ev[`PTL_EV_ABORT] = ev_abort;
      ev[`PTL_EV_UV]    = uv_ff && !uv_d_ff;
      ev[`PTL_EV_OT]    = ot_ff && !ot_d_ff;
      ev[`PTL_EV_REF]   = ev_ref;
   end

   // A new event outranks a clear in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         irq_stat_ff <= '0;
      else
         irq_stat_ff <= (irq_stat_ff & ~clr) | ev;
   end

   always_ff @(posedge clk_i or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         torque_ff    <= TQ_STANDSTILL;
         drive_en_ff  <= 1'b0;
         brake_rel_ff <= 1'b0;
         irq_ff       <= 1'b0;
      end
      else
      begin
         unique case (state_ff)
            ST_START: torque_ff <= TQ_STARTUP;
            ST_RUN:   torque_ff <= TQ_MAX;
            ST_HOLD:  torque_ff <= TQ_END_HOLD;
            default:  torque_ff <= TQ_STANDSTILL;
         endcase
         drive_en_ff  <= (state_ff == ST_START) || (state_ff == ST_RUN);
         brake_rel_ff <= (state_ff == ST_REV) || (state_ff == ST_START) || (state_ff == ST_RUN) || brk_busy_ff;
         irq_ff       <= |(irq_stat_ff & irq_en_ff);
      end
   end

   assign prdata_o    = prdata_ff;
   assign pready_o    = pready_ff;
   assign pslverr_o   = pslverr_ff;
   assign torque_o    = torque_ff;
   assign drive_en_o  = drive_en_ff;
   assign dir_o       = dir_ff;
   assign brake_rel_o = brake_rel_ff;
   assign irq_o       = irq_ff;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_ff);

   start_window_a: assert property ((state_ff == ST_START) && req && !pgf_ff && (ph_cnt_ff < start_win_ff)
      |=> (state_ff == ST_START) ##1 (torque_o == TQ_STARTUP)) else $error("start-up phase left early");
   end_hold_a: assert property ((state_ff == ST_HOLD) && (ph_cnt_ff < end_win_ff)
      |=> (state_ff == ST_HOLD)) else $error("end hold phase left early");
   reversal_pause_a: assert property ((state_ff == ST_REV) && (ph_cnt_ff < rev_ff)
      |=> (state_ff != ST_START)) else $error("reversal pause cut short");
   manual_hold_a: assert property ($rose(state_ff != ST_IDLE) && !$past(ctrl_ff[`PTL_CT_RUN])
      |-> $past(key_ms_ff) >= $past(hold_lim)) else $error("manual run before hold time");
   hold_lock_a: assert property (wr_ok && (idx == `PTL_IX_HOLD) && (state_ff != ST_IDLE)
      |=> $stable(hold_ff)) else $error("hold time changed in motion");
   gp_store_a: assert property (wr_ok && gp_hit
      |=> gp_ff[$past(gp_k)] == $past(pwdata_i)) else $error("storage write lost");
   brake_hold_a: assert property (brk_busy_ff && (brk_cnt_ff < brake_hold_ff)
      |=> brake_rel_o) else $error("brake engaged too early");
   start_gate_a: assert property ($rose(state_ff != ST_IDLE)
      |-> $past(vok_ff) && !$past(pgf_ff) && !$past(ot_ff)) else $error("run started while blocked");
   pg_block_a: assert property (pgf_ff && ((state_ff == ST_START) || (state_ff == ST_RUN))
      |=> (state_ff == ST_HOLD) ##1 !drive_en_o) else $error("drive kept on after power fail");
   slow_abort_a: assert property ((state_ff == ST_RUN) && (slow_ms_ff > abort_to_ff)
      |=> (state_ff == ST_HOLD) && irq_stat_ff[`PTL_EV_ABORT]) else $error("slow run not aborted");
   temp_inhibit_a: assert property (ot_ff && (state_ff == ST_IDLE)
      |=> (state_ff == ST_IDLE)) else $error("run started over temperature");
   irq_level_a: assert property ((irq_stat_ff & irq_en_ff) != '0
      |=> irq_o) else $error("enabled event gave no interrupt");
endmodule : ptl_drive_timer

// >>> ptl_host.sv
// Purpose: APB host model
// Assumes: One transfer at a time
// Notes:   ok low if ready never came
`timescale 1ns/1ps
module ptl_host
(
   input  wire logic        clk_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i,
   input  wire logic [31:0] prdata_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [11:0]      paddr_o,
   output logic [31:0]      pwdata_o
);
   logic [31:0] rd;
   logic        err;
   initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
   // Held to the ready edge, never timed in ns
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic ok);
      int n;
      n = 0;
      @(posedge clk_i);
      {psel_o, pwrite_o, paddr_o, pwdata_o} <= {1'b1, w, a, d};
      @(posedge clk_i);
      penable_o <= 1'b1;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (pready_i !== 1'b1 && n < 64);
      ok = pready_i;
      rd = prdata_i;
      err = pslverr_i;
      {psel_o, penable_o} <= 2'b00;
   endtask : xfer
endmodule : ptl_host

// >>> tb.sv
// Purpose: Self-checking bench
// Assumes: Tick cut to TC cycles
// Notes:   Spans get a few cycles of slack
`timescale 1ns/1ps
`include "ptl_cfg.svh"
module tb;
   import ptl_pkg::*;
   localparam int  TC = 20;
   logic           clk_i = 1'b0;
   logic           rst_n_i = 1'b0;
   logic           ps, pe, pw, prdy, perr, drv, brk, irq, dir, key = 1'b0;
   logic [11:0]    pa;
   logic [31:0]    pwd, prd;
   logic [15:0]    umot = 16'h00FA, temp = 16'h0047, spd = 16'h0000, tgt = 16'h0000;
   logic [31:0]    dv[11] = '{16'hC8, 16'hC8, 16'hC8, 16'hA, 16'h3E8, 16'h3E8, 16'h64, 16'hB9, 16'h46, 16'h1E, 16'h0};
   logic [7:0]     ix[11] = '{8'h4A, 8'h4C, 8'h4E, 8'h50, 8'h52, 8'h54, 8'h56, 8'h6C, 8'h6E, 8'h3C, 8'h58};
   ptl_torque_type tq;
   int             num_errors = 0, n_tests = 0, n, c, w;
   wire [3:0]      pr = {drv, brk, tq == TQ_MAX, tq == TQ_STANDSTILL};
   always #2.5 clk_i = ~clk_i;
   ptl_drive_timer #(.TICK_CYC(TC)) u_ptl_drive_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(ps),
      .penable_i(pe), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
      .pslverr_o(perr), .umot_i(umot), .temp_i(temp), .speed_i(spd), .target_speed_i(tgt), .manual_key_i(key),
      .torque_o(tq), .drive_en_o(drv), .dir_o(dir), .brake_rel_o(brk), .irq_o(irq));
   ptl_host u_ptl_host (.clk_i(clk_i), .pready_i(prdy), .pslverr_i(perr), .prdata_i(prd), .psel_o(ps),
      .penable_o(pe), .pwrite_o(pw), .paddr_o(pa), .pwdata_o(pwd));
   ////////////////////////////////////////
   task tally_and_finish;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task rw(input logic wr, input logic [7:0] i, input logic [31:0] d);
      logic ok;
      u_ptl_host.xfer(wr, {2'b00, i, 2'b00}, d, ok);
      if (ok !== 1'b1)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask : rw
   // Bounded wait for one probe bit
   task wt(input int b, input logic v, output int k);
      k = 0;
      while (pr[b] !== v && k < 9999)
      begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 9999)
      begin
         num_errors++;
         tally_and_finish();
      end
   endtask : wt
   function automatic logic inr(int k, int ms);
      return k >= (ms - 1) * TC && k <= ms * TC + 8;
   endfunction : inr
   ////////////////////////////////////////
   initial
   begin
      void'($urandom(17));
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      foreach (ix[i])
      begin
         rw(0, ix[i], 0);
         chk(u_ptl_host.rd, dv[i]);
      end
      for (int i = 0; i < 10; i++)
      begin
         dv[i] = $urandom;
         rw(1, 8'h58 + 8'(2 * i), dv[i]);
      end
      for (int i = 0; i < 10; i++)
      begin
         rw(0, 8'h58 + 8'(2 * i), 0);
         chk(u_ptl_host.rd, dv[i]);
      end
      rw(0, 8'h59, 0);
      chk(u_ptl_host.err, 1'b1);
      rw(1, `PTL_IX_IRQ_EN, 32'h00000011);
      rw(1, `PTL_IX_CTRL, 32'h00000001);
      repeat (4) @(posedge clk_i);
      chk({drv, irq}, 2'b01);
      rw(1, `PTL_IX_CTRL, 32'h00000000);
      rw(1, `PTL_IX_IRQ_CLR, 32'h00000010);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      // Voltage is judged only once a filter window has closed
      repeat (110 * TC) @(posedge clk_i);
      // Supply is fine now, so only the over-temperature can refuse this start
      rw(1, `PTL_IX_CTRL, 32'h00000001);
      repeat (4) @(posedge clk_i);
      chk(drv, 1'b0);
      rw(1, `PTL_IX_CTRL, 32'h00000000);
      rw(1, `PTL_IX_IRQ_CLR, 32'h00000010);
      temp <= 16'h0046;
      w = $urandom_range(5, 14);
      n = $urandom_range(100, 1000);
      spd <= 16'(n);
      tgt <= 16'(n);
      rw(1, `PTL_IX_START_WIN, 32'(w));
      rw(1, `PTL_IX_END_WIN, 32'h00000008);
      rw(1, `PTL_IX_BRAKE, 32'h00000014);
      rw(1, `PTL_IX_CTRL, 32'h00000001);
      wt(0, 1'b0, n);
      wt(1, 1'b1, n);
      chk(inr(n, w), 1'b1);
      rw(1, `PTL_IX_HOLD, 32'h00000005);
      rw(0, `PTL_IX_HOLD, 0);
      chk(u_ptl_host.rd, 32'h000003E8);
      rw(1, `PTL_IX_CTRL, 32'h00000000);
      wt(1, 1'b0, n);
      wt(0, 1'b1, n);
      chk(inr(n, 8), 1'b1);
      wt(2, 1'b0, c);
      chk(inr(n + c, 20), 1'b1);
      chk(irq, 1'b1);
      rw(1, `PTL_IX_IRQ_CLR, 32'h00000001);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b0);
      rw(1, `PTL_IX_CTRL, 32'h00000003);
      wt(3, 1'b1, n);
      chk(inr(n, 10), 1'b1);
      chk(dir, 1'b1);
      // Keep the new direction so the manual run needs no pause
      rw(1, `PTL_IX_CTRL, 32'h00000002);
      wt(0, 1'b1, n);
      rw(1, `PTL_IX_HOLD, 32'h00000002);
      key <= 1'b1;
      wt(3, 1'b1, n);
      chk(inr(n, 10), 1'b1);
      spd <= 16'h0000;
      wt(3, 1'b0, n);
      chk(inr(n, w + 201), 1'b1);
      // Key still held, so the run restarts and the low supply then aborts it
      spd <= tgt;
      umot <= 16'h00B4;
      wt(3, 1'b1, n);
      wt(3, 1'b0, n);
      rw(0, `PTL_IX_STAT, 0);
      chk(u_ptl_host.rd[13], 1'b1);
      chk(u_ptl_host.rd[1], 1'b1);
      key <= 1'b0;
      tally_and_finish();
   end
endmodule : tb
